/* File: design/ptg_cfg.svh */
// register offsets, field positions, reset values and timing counts
`ifndef PTG_CFG_SVH
`define PTG_CFG_SVH
`define PTG_REG_CTRL 8'h00
`define PTG_REG_COUNT 8'h04
`define PTG_REG_POINTS 8'h08
`define PTG_REG_INC 8'h0C
`define PTG_REG_BASE 8'h10
`define PTG_REG_AMP 8'h14
`define PTG_REG_PSEL 8'h18
`define PTG_REG_LEVEL 8'h1C
`define PTG_REG_WIDTH 8'h20
`define PTG_REG_DELAY 8'h24
`define PTG_REG_ACTW 8'h28
`define PTG_REG_ACTD 8'h2C
`define PTG_REG_STATUS 8'h30
`define PTG_REG_INDEX 8'h34
`define PTG_CTRL_RUN 0
`define PTG_CTRL_EXT 1
`define PTG_CTRL_SYS 2
`define PTG_CTRL_NEXT 3
`define PTG_CTRL_DONE 4
`define PTG_MAX_PULSES 10
`define PTG_MAX_POINTS 17'h186A0
`define PTG_RST_POINTS 17'h02710
`define PTG_RST_COUNT 4'h2
`define PTG_RST_AMP 16'h8000
`define PTG_UNITY_AMP 16'h8000
`define PTG_CLK_NS 5
`define PTG_POINT_MIN_NS 10
`define PTG_POINT_MIN_CYC ((`PTG_POINT_MIN_NS + `PTG_CLK_NS - 1) / `PTG_CLK_NS)
`endif

/* File: design/ptg_pkg.sv */
// types shared by the pulse-train generator files
package ptg_pkg;
    typedef struct packed
    {
        logic signed [15:0] level;
        logic [15:0] width;
        logic signed [16:0] delay;
    } ptg_pulse_t;
    typedef struct packed
    {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } ptg_wb_req_t;
    typedef enum logic [1:0] {BLD_IDLE, BLD_READ, BLD_CALC} ptg_bld_t;
    typedef enum logic [1:0] {CK_INT, CK_ARMED, CK_EXT} ptg_ck_t;
endpackage

/* File: design/ptg_pulse_mem.sv */
// per-pulse parameter store with field write enables and registered read
`timescale 1ns/1ps
module ptg_pulse_mem #(
    parameter int DEPTH = 10,
    parameter int AW = 4
) (
    input wire logic clk_sys_i,
    input wire logic we_i,
    input wire logic [2:0] field_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire ptg_pkg::ptg_pulse_t wr_data_i,
    input wire logic [AW-1:0] rd_addr_i,
    output ptg_pkg::ptg_pulse_t rd_data_o
);
    import ptg_pkg::*;
    ptg_pulse_t mem [DEPTH];

    // field-wise write so level, width and delay are set independently
    always_ff @(posedge clk_sys_i)
    begin
        if (we_i && field_en_i[2])
            mem[wr_addr_i].level <= wr_data_i.level;
        if (we_i && field_en_i[1])
            mem[wr_addr_i].width <= wr_data_i.width;
        if (we_i && field_en_i[0])
            mem[wr_addr_i].delay <= wr_data_i.delay;
        rd_data_o <= mem[rd_addr_i];
    end
endmodule

/* File: design/ptg_pulse_train.sv */
// pulse-train pattern generator: registers, pattern build and point playback
//
// Notes on behaviour
// R1: pulse count one to ten per train
// R2: pattern values plus per-pulse level, width, delay
// R3: rebuild only on commit and when changed; a point-count change on a built pattern rebuilds at once without a commit
// R4: period span ten ns to hundred s
// R5: period equals point count times point time
// R6: baseline level fills gaps between pulses
// R7: each pulse has its own level
// R8: amplitude scales pulses and baseline together
// R9: width quantised to points, actual reported
// R10: at most one hundred thousand points
// R11: delay limited to period less one point
// R12: operator keeps pulses apart and inside period
// R13: period change rescales widths and delays proportionally
// R14: frequency path keeps point count fixed
// R15: setup path sets point count for period
// R16: point clock selectable internal or external source
// R17: switch to external at first rising edge
// R18: external mode advances one point per edge
// R19: point time never below ten ns
// R20: point count and point time both adjustable
// R21: waveform sync once per train at zero point
`timescale 1ns/1ps
`include "ptg_cfg.svh"
module ptg_pulse_train #(
    parameter int NPULSE = `PTG_MAX_PULSES,
    parameter int PW = 17
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire ptg_pkg::ptg_wb_req_t wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_arb_clk_i,
    input wire logic sys_ref_clk_i,
    output logic signed [15:0] level_o,
    output logic sync_o
);
    import ptg_pkg::*;
    localparam logic [32:0] INC_LIM33 = 33'h100000000 / 33'(`PTG_POINT_MIN_CYC);
    localparam logic [31:0] INC_MAX = INC_LIM33[31:0];
    localparam logic [3:0] NP4 = 4'(NPULSE);

    ////////////////////////////////////////////////////////////////////////
    // wishbone decode
    wire wb_hit = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    wire wr_en = wb_hit && wb_req_i.we;
    wire [7:0] adr = wb_req_i.adr;
    wire [31:0] bmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                         {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
    wire wr_ctrl = wr_en && adr == `PTG_REG_CTRL;
    wire wr_count = wr_en && adr == `PTG_REG_COUNT;
    wire wr_points = wr_en && adr == `PTG_REG_POINTS;
    wire wr_inc = wr_en && adr == `PTG_REG_INC;
    wire wr_base = wr_en && adr == `PTG_REG_BASE;
    wire wr_amp = wr_en && adr == `PTG_REG_AMP;
    wire wr_psel = wr_en && adr == `PTG_REG_PSEL;
    wire wr_lvl = wr_en && adr == `PTG_REG_LEVEL;
    wire wr_wid = wr_en && adr == `PTG_REG_WIDTH;
    wire wr_dly = wr_en && adr == `PTG_REG_DELAY;

    // byte-lane merge of a write into the current value
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nv,
                                           input logic [31:0] m);
        wmerge = (old & ~m) | (nv & m);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // settings registers
    logic run, ext_sel, sys_src, dirty, built;
    logic [3:0] count, psel;
    logic [PW-1:0] points;
    logic [31:0] inc;
    logic signed [15:0] baseline;
    logic [15:0] amp;
    ptg_bld_t bld;
    logic [3:0] bi;

    wire [31:0] ctrl_m = wmerge({27'h0, 2'h0, sys_src, ext_sel, run}, wb_req_i.dat, bmask);
    wire [31:0] cnt_m = wmerge({28'h0, count}, wb_req_i.dat, bmask);
    wire [31:0] pts_m = wmerge({15'h0, points}, wb_req_i.dat, bmask);
    wire [31:0] inc_m = wmerge(inc, wb_req_i.dat, bmask);
    wire [31:0] base_m = wmerge({16'h0, baseline}, wb_req_i.dat, bmask);
    wire [31:0] amp_m = wmerge({16'h0, amp}, wb_req_i.dat, bmask);
    wire [31:0] psel_m = wmerge({28'h0, psel}, wb_req_i.dat, bmask);
    // out-of-range entries are pulled into the legal span, not refused
    wire [3:0] next_count = (cnt_m[31:4] != 28'h0 || cnt_m[3:0] > NP4) ? NP4 :
                            (cnt_m[3:0] == 4'h0) ? 4'h1 : cnt_m[3:0]; // [R1]
    wire [PW-1:0] next_points = (pts_m[31:PW] != '0 || pts_m[PW-1:0] > `PTG_MAX_POINTS) ?
                                `PTG_MAX_POINTS :
                                (pts_m[PW-1:0] == '0) ? PW'(1) : pts_m[PW-1:0]; // [R10]
    wire [31:0] next_inc = (inc_m > INC_MAX) ? INC_MAX :
                           (inc_m == 32'h0) ? 32'h1 : inc_m; // [R19]
    wire [3:0] next_psel = (psel_m[3:0] >= NP4) ? NP4 - 4'h1 : psel_m[3:0];
    wire commit = wr_ctrl && (wb_req_i.dat[`PTG_CTRL_NEXT] || wb_req_i.dat[`PTG_CTRL_DONE]);
    wire pts_chg = wr_points && next_points != points;
    // a period change after definition rebuilds at once from stored fractions
    wire start_build = (commit && dirty) || (pts_chg && built); // [R3] [R13]
    // a period change on a built pattern starts its own rebuild, so it clears dirty instead of setting it
    wire par_wr = wr_count || wr_lvl || wr_wid || wr_dly || (pts_chg && !built);

    // settings: point count only via its own register, rate also via inc
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            run <= 1'b0;
            ext_sel <= 1'b0;
            sys_src <= 1'b0;
            count <= `PTG_RST_COUNT;
            points <= `PTG_RST_POINTS;
            inc <= INC_MAX;
            baseline <= 16'h0000;
            amp <= `PTG_RST_AMP;
            psel <= 4'h0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                run <= ctrl_m[`PTG_CTRL_RUN];
                ext_sel <= ctrl_m[`PTG_CTRL_EXT]; // [R16]
                sys_src <= ctrl_m[`PTG_CTRL_SYS];
            end
            if (wr_count)
                count <= next_count; // [R1] [R2]
            if (wr_points)
                points <= next_points; // [R5] [R15] [R20]
            if (wr_inc)
                inc <= next_inc; // [R14] [R4]
            if (wr_base)
                baseline <= base_m[15:0]; // [R6]
            if (wr_amp)
                amp <= amp_m[15:0];
            if (wr_psel)
                psel <= next_psel;
        end
    end

    // change tracking: a change during a build wins over the build's clear
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            dirty <= 1'b0;
            built <= 1'b0;
        end
        else
        begin
            if (par_wr)
                dirty <= 1'b1;
            else if (bld == BLD_IDLE && start_build)
                dirty <= 1'b0; // [R3]
            if (bld == BLD_CALC && bi == NP4 - 4'h1)
                built <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // parameter store
    ptg_pulse_t mem_wr, mem_rd;
    assign mem_wr = '{level: wb_req_i.dat[15:0], width: wb_req_i.dat[15:0],
                      delay: wb_req_i.dat[16:0]};

    ptg_pulse_mem #(.DEPTH(NPULSE), .AW(4)) u_mem (
        .clk_sys_i(clk_sys_i),
        .we_i(wr_lvl || wr_wid || wr_dly),
        .field_en_i({wr_lvl, wr_wid, wr_dly}), // [R7] [R2]
        .wr_addr_i(psel),
        .wr_data_i(mem_wr),
        .rd_addr_i(bi),
        .rd_data_o(mem_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    // build: fractions of the period become whole points
    wire [32:0] wprod = {17'h0, mem_rd.width} * {16'h0, points};
    wire [PW-1:0] wq = wprod[32:16];
    wire [PW-1:0] wid_p = (wq == '0) ? PW'(1) : wq; // [R9]
    wire dneg = mem_rd.delay[16];
    wire [16:0] dmag = dneg ? 17'(-mem_rd.delay) : mem_rd.delay;
    wire [33:0] dprod = {17'h0, dmag} * {17'h0, points};
    wire [17:0] dq = dprod[33:16];
    wire [PW-1:0] dlim = (dq >= {1'b0, points}) ? points - PW'(1) : dq[PW-1:0]; // [R11]
    // a negative delay lands before the sync, i.e. late in the previous train
    wire [PW-1:0] start_p = (dneg && dlim != '0) ? points - dlim : dlim;

    logic [PW-1:0] st_pts [NPULSE];
    logic [PW-1:0] wd_pts [NPULSE];
    logic signed [15:0] lv [NPULSE];
    logic [NPULSE-1:0] pen;

    // one pulse per two cycles keeps a single multiplier pair
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            bld <= BLD_IDLE;
            bi <= 4'h0;
            pen <= '0;
        end
        else
        begin
            case (bld)
                BLD_IDLE:
                begin
                    bi <= 4'h0;
                    if (start_build)
                        bld <= BLD_READ;
                end
                BLD_READ:
                    bld <= BLD_CALC;
                BLD_CALC:
                begin
                    st_pts[bi] <= start_p;
                    wd_pts[bi] <= wid_p; // [R9]
                    lv[bi] <= mem_rd.level; // [R7]
                    pen[bi] <= bi < count; // [R1]
                    if (bi == NP4 - 4'h1)
                        bld <= BLD_IDLE;
                    else
                    begin
                        bi <= bi + 4'h1;
                        bld <= BLD_READ;
                    end
                end
                default:
                    bld <= BLD_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // point clock: fractional synthesis or external edges
    logic arb_s1, arb_s2, arb_s3, ref_s1, ref_s2, ref_s3;
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            {arb_s1, arb_s2, arb_s3} <= 3'h0;
            {ref_s1, ref_s2, ref_s3} <= 3'h0;
        end
        else
        begin
            {arb_s1, arb_s2, arb_s3} <= {ext_arb_clk_i, arb_s1, arb_s2};
            {ref_s1, ref_s2, ref_s3} <= {sys_ref_clk_i, ref_s1, ref_s2};
        end
    end
    wire arb_edge = arb_s2 && !arb_s3;
    wire ref_edge = ref_s2 && !ref_s3;
    wire src_edge = sys_src ? ref_edge : arb_edge; // [R16]

    ptg_ck_t ck;
    logic [31:0] acc;
    logic [PW-1:0] idx;
    wire [32:0] acc_sum = {1'b0, acc} + {1'b0, inc};
    // inc capped at half scale: a point never shorter than the minimum
    wire int_tick = acc_sum[32]; // [R19] [R20]
    wire tick = (ck == CK_EXT) ? src_edge : int_tick; // [R18]
    wire wrap = idx >= points - PW'(1);
    wire [PW-1:0] next_idx = wrap ? '0 : idx + PW'(1); // [R5]

    // internal clock keeps playing until the chosen source shows an edge
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
            ck <= CK_INT;
        else
        begin
            case (ck)
                CK_INT:
                    if (ext_sel)
                        ck <= CK_ARMED;
                CK_ARMED:
                    if (!ext_sel)
                        ck <= CK_INT;
                    else if (src_edge)
                        ck <= CK_EXT; // [R17]
                CK_EXT:
                    if (!ext_sel)
                        ck <= CK_INT;
                default:
                    ck <= CK_INT;
            endcase
        end
    end

    // point index and waveform sync
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            acc <= 32'h0;
            idx <= '0;
            sync_o <= 1'b0;
        end
        else
        begin
            acc <= acc_sum[31:0];
            sync_o <= run && tick && wrap; // [R21]
            if (run && tick)
                idx <= next_idx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse hit per entry, lowest index wins on overlap
    logic [NPULSE-1:0] hit;
    logic signed [15:0] pick [NPULSE+1];
    assign pick[NPULSE] = baseline; // [R6]
    genvar gp;
    generate
        for (gp = 0; gp < NPULSE; gp++)
        begin : g_hit
            wire [PW-1:0] rel = (idx >= st_pts[gp]) ? idx - st_pts[gp]
                                                    : idx + points - st_pts[gp];
            assign hit[gp] = built && pen[gp] && rel < wd_pts[gp]; // [R11]
            assign pick[gp] = hit[gp] ? lv[gp] : pick[gp+1]; // [R7]
        end
    endgenerate

    // one factor for pulses and baseline, unity at half scale
    wire signed [32:0] scaled = pick[0] * $signed({1'b0, amp}); // [R8]
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
            level_o <= 16'h0000;
        else
            level_o <= scaled[30:15]; // [R8]
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux and ack: one wait-free cycle, unmapped reads return zero
    logic [31:0] rd_mux;
    always_comb
    begin
        case (adr)
            `PTG_REG_CTRL: rd_mux = {29'h0, sys_src, ext_sel, run};
            `PTG_REG_COUNT: rd_mux = {28'h0, count};
            `PTG_REG_POINTS: rd_mux = {15'h0, points};
            `PTG_REG_INC: rd_mux = inc;
            `PTG_REG_BASE: rd_mux = {16'h0, baseline};
            `PTG_REG_AMP: rd_mux = {16'h0, amp};
            `PTG_REG_PSEL: rd_mux = {28'h0, psel};
            `PTG_REG_ACTW: rd_mux = {15'h0, wd_pts[psel]}; // [R9]
            `PTG_REG_ACTD: rd_mux = {15'h0, st_pts[psel]};
            `PTG_REG_STATUS: rd_mux = {27'h0, ck == CK_EXT, ck == CK_ARMED, built, dirty,
                                       bld != BLD_IDLE};
            `PTG_REG_INDEX: rd_mux = {15'h0, idx};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= wb_hit ? rd_mux : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    count_range_a: assert property (count >= 4'h1 && count <= NP4) // [R1]
        else $error("pulse count out of range");
    commit_only_a: assert property (bld == BLD_IDLE && !start_build |=> bld == BLD_IDLE) // [R3]
        else $error("build started without a commit");
    commit_go_a: assert property (bld == BLD_IDLE && commit && dirty |=> bld == BLD_READ) // [R3]
        else $error("commit with changes did not build");
    points_cap_a: assert property (points != '0 && points <= `PTG_MAX_POINTS) // [R10]
        else $error("point count out of range");
    rate_cap_a: assert property (inc <= INC_MAX ##1 !(int_tick && $past(int_tick))) // [R19]
        else $error("point time below minimum");
    width_min_a: assert property (bld == BLD_CALC && bi < count |->
                                  wid_p != '0 && wid_p <= points) // [R9]
        else $error("built width not in whole points");
    delay_cap_a: assert property (bld == BLD_CALC && bi < count |-> start_p < points) // [R11]
        else $error("delay beyond period less one point");
    ext_wait_a: assert property (ck == CK_ARMED && ext_sel && !src_edge |=> ck == CK_ARMED) // [R17]
        else $error("switched to external without an edge");
    ext_step_a: assert property (ck == CK_EXT && ext_sel && run && src_edge |=>
                                 idx == $past(next_idx)) // [R18]
        else $error("external edge did not advance a point");
    sync_zero_a: assert property (sync_o |-> idx == '0) // [R21]
        else $error("sync away from point zero");
    base_gap_a: assert property (hit == '0 && amp == `PTG_UNITY_AMP |=>
                                 level_o == $past(baseline)) // [R6]
        else $error("gap not at baseline");
    rescale_a: assert property (bld == BLD_IDLE && pts_chg && built |=> bld == BLD_READ) // [R13]
        else $error("period change did not rescale");
endmodule

/* File: tb/ptg_clk_src.sv */
// far-side point clock source: an external sample or system clock pin driver
`timescale 1ns/1ps
module ptg_clk_src #(
    parameter real HALF_NS = 40.0
) (
    input wire logic en_i,
    output logic clk_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // edges only while enabled; the pin rests low between runs so that no stale
    // edge can arm the switch-over early
    initial
    begin
        clk_o = 1'b0;
        #3;
        forever
        begin
            #(HALF_NS);
            clk_o = en_i ? ~clk_o : 1'b0;
        end
    end
endmodule

/* File: tb/ptg_pulse_train_tb.sv */
// self-checking bench for the pulse-train generator
`timescale 1ns/1ps
`include "ptg_cfg.svh"
module ptg_pulse_train_tb;
    import ptg_pkg::*;
    localparam int LIMIT = 30000;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    ptg_wb_req_t wb_req = '0;
    logic [31:0] wb_dat;
    logic wb_ack;
    logic ext_en = 1'b0;
    logic sys_en = 1'b0;
    logic ext_clk;
    logic sys_clk;
    logic signed [15:0] level;
    logic sync;
    logic [31:0] rd;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    // behavioural model state
    int pts = 20;
    int amp = 32'h4000;
    int base = 0;
    int cnt = 2;
    int ctrl = 1;
    int lvl [10];
    int wdf [10];
    int dlf [10];
    int wd [10];
    int st [10];
    localparam logic [7:0] RA [9] = '{`PTG_REG_CTRL, `PTG_REG_COUNT, `PTG_REG_POINTS,
        `PTG_REG_INC, `PTG_REG_BASE, `PTG_REG_AMP, `PTG_REG_PSEL, `PTG_REG_STATUS, 8'h3C};
    localparam logic [31:0] RV [9] = '{32'h0, 32'h2, 32'h2710, 32'h80000000, 32'h0,
        32'h8000, 32'h0, 32'h0, 32'h0};
    localparam logic [7:0] CA [7] = '{`PTG_REG_COUNT, `PTG_REG_COUNT, `PTG_REG_POINTS,
        `PTG_REG_POINTS, `PTG_REG_POINTS, `PTG_REG_INC, `PTG_REG_INC};
    localparam logic [31:0] CW [7] = '{32'h0, 32'hB, 32'h0, 32'h30D40, 32'h186A0,
        32'hFFFFFFFF, 32'h0};
    localparam logic [31:0] CE [7] = '{32'h1, 32'hA, 32'h1, 32'h186A0, 32'h186A0,
        32'h80000000, 32'h1};

    ////////////////////////////////////////////////////////////////////////////////
    // system clock, cycle budget and the two far-side clock sources
    always #2.5 clk_sys_i = ~clk_sys_i;

    always @(posedge clk_sys_i)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            num_errors++;
            summarize();
        end
    end

    ptg_clk_src #(.HALF_NS(40.0)) i_ext (.en_i(ext_en), .clk_o(ext_clk));
    ptg_clk_src #(.HALF_NS(60.0)) i_sys (.en_i(sys_en), .clk_o(sys_clk));

    ptg_pulse_train i_dut (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .wb_req_i(wb_req),
        .wb_dat_o(wb_dat),
        .wb_ack_o(wb_ack),
        .ext_arb_clk_i(ext_clk),
        .sys_ref_clk_i(sys_clk),
        .level_o(level),
        .sync_o(sync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // checking and bus helpers
    task automatic summarize();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // entered just after an edge; returns one edge after release so cyc idles a cycle
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
        // no local limit: only the cycle budget ends a missing acknowledge
        do
        begin
            @(posedge clk_sys_i);
        end
        while (wb_ack !== 1'b1);
        rd = wb_dat;
        wb_req <= '0;
        @(posedge clk_sys_i);
    endtask

    task automatic set_pulse(input int p, input int w, input int d);
        lvl[p] = $signed(16'($urandom));
        wdf[p] = w;
        dlf[p] = d;
        wb(1'b1, `PTG_REG_PSEL, 32'(p));
        wb(1'b1, `PTG_REG_LEVEL, 32'(lvl[p] & 32'hFFFF));
        wb(1'b1, `PTG_REG_WIDTH, 32'(w));
        wb(1'b1, `PTG_REG_DELAY, 32'(d & 32'h1FFFF));
    endtask

    // model placement: widths and delays are fractions of the period in points
    task automatic place();
        int dd;
        for (int p = 0; p < cnt; p++)
        begin
            wd[p] = wdf[p] * pts / 65536;
            if (wd[p] < 1)
                wd[p] = 1;
            dd = (dlf[p] < 0 ? -dlf[p] : dlf[p]) * pts / 65536;
            if (dd > pts - 1)
                dd = pts - 1;
            st[p] = dlf[p] < 0 ? (pts - dd) % pts : dd;
        end
    endtask

    function automatic int level_at(input int idx);
        for (int p = 0; p < cnt; p++)
            if ((idx - st[p] + pts) % pts < wd[p])
                return (lvl[p] * amp) >>> 15;
        return (base * amp) >>> 15;
    endfunction

    task automatic build_check();
        wb(1'b1, `PTG_REG_CTRL, 32'(ctrl | 32'h10));
        for (int k = 0; k < 20; k++)
        begin
            wb(1'b0, `PTG_REG_STATUS, 32'h0);
            if (rd[0] !== 1'b1)
                break;
        end
        chk(rd, 32'h4);
        place();
        for (int p = 0; p < cnt; p++)
        begin
            wb(1'b1, `PTG_REG_PSEL, 32'(p));
            wb(1'b0, `PTG_REG_ACTW, 32'h0);
            chk(rd, 32'(wd[p]));
            wb(1'b0, `PTG_REG_ACTD, 32'h0);
            chk(rd, 32'(st[p]));
        end
    endtask

    task automatic wait_sync();
        int k;
        k = 0;
        do
        begin
            @(posedge clk_sys_i);
            k++;
        end
        while (sync !== 1'b1 && k < 4000);
    endtask

    task automatic period_is(input int exp);
        int k;
        wait_sync();
        k = 0;
        do
        begin
            @(posedge clk_sys_i);
            k++;
        end
        while (sync !== 1'b1 && k < 4000);
        chk(32'(k), 32'(exp));
    endtask

    // one sample in the second cycle of every point, two cycles per point
    task automatic play_check();
        wait_sync();
        for (int k = 0; k < pts; k++)
        begin
            @(posedge clk_sys_i);
            chk({16'h0000, level}, {16'h0000, 16'(level_at(k))});
            @(posedge clk_sys_i);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        void'($urandom(90786));
        repeat (6) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
        foreach (RA[i])
        begin
            wb(1'b0, RA[i], 32'h0);
            chk(rd, RV[i]);
        end
        foreach (CA[i])
        begin
            wb(1'b1, CA[i], CW[i]);
            wb(1'b0, CA[i], 32'h0);
            chk(rd, CE[i]);
        end
        cnt = $urandom_range(1, 10);
        wb(1'b1, `PTG_REG_COUNT, 32'(cnt));
        wb(1'b0, `PTG_REG_COUNT, 32'h0);
        chk(rd, 32'(cnt));
        // two-pulse train on 20 points of 10 ns, half amplitude
        cnt = 2;
        base = $signed(16'($urandom));
        wb(1'b1, `PTG_REG_COUNT, 32'h2);
        wb(1'b1, `PTG_REG_POINTS, 32'(pts));
        wb(1'b1, `PTG_REG_INC, 32'h80000000);
        wb(1'b1, `PTG_REG_BASE, 32'(base & 32'hFFFF));
        wb(1'b1, `PTG_REG_AMP, 32'(amp));
        wb(1'b1, `PTG_REG_CTRL, 32'(ctrl));
        set_pulse(0, 32'h3000, 32'h1000);
        set_pulse(1, 32'h2000, -32'h4000);
        wb(1'b0, `PTG_REG_STATUS, 32'h0);
        chk(rd, 32'h2);
        build_check();
        play_check();
        period_is(40);
        // commit through the next bit with nothing changed must not rebuild
        wb(1'b1, `PTG_REG_CTRL, 32'(ctrl | 32'h8));
        wb(1'b0, `PTG_REG_STATUS, 32'h0);
        chk(rd, 32'h4);
        // setup path: doubling the point count rescales the pattern
        pts = 40;
        wb(1'b1, `PTG_REG_POINTS, 32'(pts));
        build_check();
        play_check();
        period_is(80);
        // frequency path: slower point rate, point count untouched
        wb(1'b1, `PTG_REG_INC, 32'h40000000);
        wb(1'b0, `PTG_REG_POINTS, 32'h0);
        chk(rd, 32'(pts));
        period_is(160);
        wb(1'b1, `PTG_REG_INC, 32'h80000000);
        // full amplitude: programmed levels and baseline appear unscaled
        amp = 32'h8000;
        wb(1'b1, `PTG_REG_AMP, 32'(amp));
        play_check();
        // external pin selected but silent: still runs on the internal rate
        ctrl = 3;
        wb(1'b1, `PTG_REG_CTRL, 32'(ctrl));
        wb(1'b0, `PTG_REG_STATUS, 32'h0);
        chk(rd, 32'hC);
        period_is(80);
        ext_en <= 1'b1;
        repeat (40) @(posedge clk_sys_i);
        wb(1'b0, `PTG_REG_STATUS, 32'h0);
        chk(rd, 32'h14);
        period_is(40 * 16);
        // shared system clock as the source, slower than the pin clock
        ext_en <= 1'b0;
        ctrl = 1;
        wb(1'b1, `PTG_REG_CTRL, 32'(ctrl));
        ctrl = 7;
        wb(1'b1, `PTG_REG_CTRL, 32'(ctrl));
        sys_en <= 1'b1;
        repeat (40) @(posedge clk_sys_i);
        period_is(40 * 24);
        summarize();
    end
endmodule
